// File: rtl/instr_timing_pkg.sv
// Package of instruction classes, operand forms and cycle figures
package instr_timing_pkg;

  typedef enum logic [5:0] {
    OP_ADD_IMMEDIATE, OP_AND_IMMEDIATE, OP_XOR_IMMEDIATE, OP_OR_IMMEDIATE,
    OP_SUBTRACT_IMMEDIATE, OP_COMPARE_IMMEDIATE, OP_ADD_QUICK, OP_SUBTRACT_QUICK,
    OP_LOAD_QUICK_CONSTANT, OP_CLEAR_OPERAND, OP_DECIMAL_NEGATE, OP_TWOS_NEGATE,
    OP_NEGATE_WITH_EXTEND, OP_INVERT_OPERAND, OP_SET_ON_CONDITION,
    OP_TEST_AND_SET_OPERAND, OP_TEST_OPERAND, OP_ARITHMETIC_SHIFT, OP_LOGICAL_SHIFT,
    OP_PLAIN_ROTATE, OP_ROTATE_THROUGH_EXTEND, OP_BIT_TOGGLE, OP_BIT_CLEAR_OP,
    OP_BIT_SET_OP, OP_BIT_TEST_OP, OP_CONDITIONAL_BRANCH, OP_UNCONDITIONAL_JUMP_REL,
    OP_SUBROUTINE_CALL_REL, OP_LOOP_DECREMENT_BRANCH, OP_BOUNDS_CHECK_EXCEPTION,
    OP_SOFTWARE_EXCEPTION, OP_OVERFLOW_EXCEPTION
  } op_t;

  typedef enum logic [1:0] {SIZE_BYTE, SIZE_WORD, SIZE_LONG} size_t;

  typedef enum logic [1:0] {
    DST_DATA_REG_OPERAND, DST_ADDR_REG_OPERAND, DST_MEMORY
  } dst_t;

  localparam int CLK_W = 8;
  localparam int BUS_W = 5;
  localparam int SHIFT_W = 6;

  localparam logic [CLK_W-1:0] SHIFT_BASE_BW = 8'h0A;
  localparam logic [CLK_W-1:0] SHIFT_BASE_L = 8'h0C;
  localparam logic [CLK_W-1:0] CLOCKS_PER_STEP = 8'h02;
  localparam logic [CLK_W-1:0] CLOCKS_PER_BUS = 8'h04;

endpackage

// File: rtl/instr_cycle_timing.sv
// Instruction execution sequencer: clock and bus cycle counts per form
`timescale 1ns/1ps
`default_nettype none

module instr_cycle_timing (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire instr_timing_pkg::op_t op_i,
  input wire instr_timing_pkg::size_t size_i,
  input wire instr_timing_pkg::dst_t dst_i,
  input wire logic word_disp_i,
  input wire logic cond_true_i,
  input wire logic loop_expired_i,
  input wire logic static_bit_i,
  input wire logic [instr_timing_pkg::SHIFT_W-1:0] shift_count_i,
  input wire logic [instr_timing_pkg::CLK_W-1:0] ea_clocks_i,
  input wire logic [instr_timing_pkg::BUS_W-1:0] ea_reads_i,
  input wire logic [instr_timing_pkg::BUS_W-1:0] ea_writes_i,
  output logic busy_o,
  output logic done_o,
  output logic read_cycle_o,
  output logic write_cycle_o,
  output logic [instr_timing_pkg::CLK_W-1:0] clocks_o,
  output logic [instr_timing_pkg::BUS_W-1:0] reads_o,
  output logic [instr_timing_pkg::BUS_W-1:0] writes_o
);
  import instr_timing_pkg::*;

  // ----------------------------------------
  // Timing lookup
  // ----------------------------------------
  logic [CLK_W-1:0] base_clk;
  logic [BUS_W-1:0] base_rd;
  logic [BUS_W-1:0] base_wr;
  logic add_ea;

  always_comb begin
    logic mem, lng;
    mem = (dst_i == DST_MEMORY);
    lng = (size_i == SIZE_LONG);
    base_clk = 8'h08;
    base_rd = 5'h02;
    base_wr = 5'h00;
    add_ea = 1'b0;
    unique case (op_i)
      OP_ADD_IMMEDIATE, OP_AND_IMMEDIATE, OP_XOR_IMMEDIATE, OP_OR_IMMEDIATE,
      OP_SUBTRACT_IMMEDIATE: begin
        if (mem && op_i != OP_SUBTRACT_IMMEDIATE) begin
          add_ea = 1'b1;
          unique case (size_i)
            SIZE_BYTE: begin base_clk = 8'h14; base_rd = 5'h04; base_wr = 5'h01; end
            SIZE_WORD: begin base_clk = 8'h18; base_rd = 5'h04; base_wr = 5'h02; end
            default: begin base_clk = 8'h28; base_rd = 5'h06; base_wr = 5'h04; end
          endcase
        end else if (mem) begin
          add_ea = 1'b1;
          unique case (size_i)
            SIZE_BYTE: begin base_clk = 8'h0C; base_wr = 5'h01; end
            SIZE_WORD: begin base_clk = 8'h10; base_wr = 5'h02; end
            default: begin base_clk = 8'h18; base_wr = 5'h04; end
          endcase
        end else begin
          base_clk = lng ? 8'h1C : 8'h10;
          base_rd = lng ? 5'h06 : 5'h04;
        end
      end
      OP_COMPARE_IMMEDIATE: begin
        base_rd = lng ? 5'h06 : 5'h04;
        base_clk = mem ? (lng ? 8'h18 : 8'h10) : (lng ? 8'h1A : 8'h10);
      end
      OP_ADD_QUICK, OP_SUBTRACT_QUICK: begin
        if (dst_i == DST_ADDR_REG_OPERAND) base_clk = 8'h0C;
        else if (mem) begin
          add_ea = 1'b1;
          if (op_i == OP_ADD_QUICK) begin
            unique case (size_i)
              SIZE_BYTE: begin base_clk = 8'h0C; base_wr = 5'h01; end
              SIZE_WORD: begin base_clk = 8'h10; base_wr = 5'h02; end
              default: begin base_clk = 8'h18; base_wr = 5'h04; end
            endcase
          end else begin
            unique case (size_i)
              SIZE_BYTE: begin base_clk = 8'h14; base_rd = 5'h04; base_wr = 5'h01; end
              SIZE_WORD: begin base_clk = 8'h18; base_rd = 5'h04; base_wr = 5'h02; end
              default: begin base_clk = 8'h28; base_rd = 5'h06; base_wr = 5'h04; end
            endcase
          end
        end else begin
          base_clk = lng ? 8'h0C : 8'h08;
        end
      end
      OP_LOAD_QUICK_CONSTANT: base_clk = 8'h08;
      OP_CLEAR_OPERAND, OP_TWOS_NEGATE, OP_NEGATE_WITH_EXTEND, OP_INVERT_OPERAND: begin
        if (mem) begin
          add_ea = 1'b1;
          unique case (size_i)
            SIZE_BYTE: begin base_clk = 8'h0C; base_wr = 5'h01; end
            SIZE_WORD: begin base_clk = 8'h10; base_wr = 5'h02; end
            default: begin base_clk = 8'h18; base_wr = 5'h04; end
          endcase
        end else begin
          base_clk = lng ? 8'h0A : 8'h08;
        end
      end
      OP_DECIMAL_NEGATE: begin
        add_ea = mem;
        base_clk = mem ? 8'h0C : 8'h0A;
        base_wr = mem ? 5'h01 : 5'h00;
      end
      OP_SET_ON_CONDITION: begin
        add_ea = mem;
        base_clk = mem ? 8'h0C : (cond_true_i ? 8'h0A : 8'h08);
        base_wr = mem ? 5'h01 : 5'h00;
      end
      OP_TEST_AND_SET_OPERAND: begin
        add_ea = mem;
        base_clk = mem ? 8'h0E : 8'h08;
        base_wr = mem ? 5'h01 : 5'h00;
      end
      OP_TEST_OPERAND: add_ea = mem;
      OP_ARITHMETIC_SHIFT, OP_LOGICAL_SHIFT, OP_PLAIN_ROTATE, OP_ROTATE_THROUGH_EXTEND: begin
        if (mem) begin
          add_ea = 1'b1;
          base_clk = 8'h10;
          base_wr = 5'h02;
        end else begin
          base_clk = (lng ? SHIFT_BASE_L : SHIFT_BASE_BW)
            + CLOCKS_PER_STEP * CLK_W'(shift_count_i);
        end
      end
      OP_BIT_TOGGLE, OP_BIT_CLEAR_OP, OP_BIT_SET_OP, OP_BIT_TEST_OP: begin
        if (static_bit_i) begin
          base_rd = 5'h04;
          if (mem) begin
            add_ea = 1'b1;
            base_clk = (op_i == OP_BIT_TEST_OP) ? 8'h10 : 8'h14;
            base_wr = (op_i == OP_BIT_TEST_OP) ? 5'h00 : 5'h01;
          end else if (op_i == OP_BIT_TEST_OP) base_clk = 8'h12;
          else if (op_i == OP_BIT_CLEAR_OP) base_clk = 8'h16;
          else base_clk = 8'h14;
        end else begin
          if (mem) begin
            add_ea = 1'b1;
            base_clk = (op_i == OP_BIT_TEST_OP) ? 8'h08 : 8'h0C;
            base_wr = (op_i == OP_BIT_TEST_OP) ? 5'h00 : 5'h01;
          end else if (op_i == OP_BIT_TEST_OP) base_clk = 8'h0A;
          else if (op_i == OP_BIT_CLEAR_OP) base_clk = 8'h0E;
          else base_clk = 8'h0C;
        end
      end
      OP_CONDITIONAL_BRANCH, OP_UNCONDITIONAL_JUMP_REL: begin
        base_rd = 5'h04;
        if (op_i == OP_UNCONDITIONAL_JUMP_REL || cond_true_i) base_clk = 8'h12;
        else if (word_disp_i) base_clk = 8'h14;
        else begin
          base_clk = 8'h0C;
          base_rd = 5'h02;
        end
      end
      OP_SUBROUTINE_CALL_REL: begin
        base_clk = 8'h22;
        base_rd = 5'h04;
        base_wr = 5'h04;
      end
      OP_LOOP_DECREMENT_BRANCH: begin
        base_rd = 5'h04;
        if (cond_true_i) base_clk = 8'h14;
        else if (loop_expired_i) begin
          base_clk = 8'h1A;
          base_rd = 5'h06;
        end else base_clk = 8'h12;
      end
      OP_BOUNDS_CHECK_EXCEPTION: begin
        // Bounds check, address cost when raised
        add_ea = cond_true_i;
        if (cond_true_i) begin
          base_clk = 8'h44;
          base_rd = 5'h08;
          base_wr = 5'h06;
        end else base_clk = 8'h0E;
      end
      OP_SOFTWARE_EXCEPTION: begin
        base_clk = 8'h3E;
        base_rd = 5'h08;
        base_wr = 5'h06;
      end
      OP_OVERFLOW_EXCEPTION: begin
        if (cond_true_i) begin
          base_clk = 8'h42;
          base_rd = 5'h0A;
          base_wr = 5'h06;
        end
      end
      default: base_clk = 8'h08;
    endcase
  end

  // ----------------------------------------
  // Execution counter
  // ----------------------------------------
  logic busy_q, busy_d, done_q, done_d, rd_q, rd_d, wr_q, wr_d;
  logic [CLK_W-1:0] left_q, left_d, clocks_q, clocks_d, tot_q, tot_d, sub_q, sub_d;
  logic [BUS_W-1:0] rd_left_q, rd_left_d, wr_left_q, wr_left_d;
  logic [BUS_W-1:0] reads_q, reads_d, writes_q, writes_d, tr_q, tr_d, tw_q, tw_d;

  always_comb begin
    busy_d = busy_q;
    done_d = 1'b0;
    rd_d = 1'b0;
    wr_d = 1'b0;
    left_d = left_q;
    clocks_d = clocks_q;
    tot_d = tot_q;
    sub_d = sub_q;
    rd_left_d = rd_left_q;
    wr_left_d = wr_left_q;
    reads_d = reads_q;
    writes_d = writes_q;
    tr_d = tr_q;
    tw_d = tw_q;
    if (!busy_q && start_i) begin
      busy_d = 1'b1;
      left_d = base_clk + (add_ea ? ea_clocks_i : '0);
      rd_left_d = base_rd + (add_ea ? ea_reads_i : '0);
      wr_left_d = base_wr + (add_ea ? ea_writes_i : '0);
      tot_d = '0;
      tr_d = '0;
      tw_d = '0;
      sub_d = 8'h01;
    end else if (busy_q) begin
      tot_d = tot_q + 8'h01;
      sub_d = sub_q + 8'h01;
      if (sub_q == CLOCKS_PER_BUS - 8'h01) begin
        sub_d = '0;
        if (rd_left_q != '0) begin
          rd_d = 1'b1;
          rd_left_d = rd_left_q - 5'h01;
          tr_d = tr_q + 5'h01;
        end else if (wr_left_q != '0) begin
          wr_d = 1'b1;
          wr_left_d = wr_left_q - 5'h01;
          tw_d = tw_q + 5'h01;
        end
      end
      left_d = left_q - 8'h01;
      if (left_q == 8'h01) begin
        busy_d = 1'b0;
        done_d = 1'b1;
        clocks_d = tot_q + 8'h01;
        reads_d = tr_q + rd_left_q;
        writes_d = tw_q + wr_left_q;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      left_q <= '0;
      clocks_q <= '0;
      tot_q <= '0;
      sub_q <= '0;
      rd_left_q <= '0;
      wr_left_q <= '0;
      reads_q <= '0;
      writes_q <= '0;
      tr_q <= '0;
      tw_q <= '0;
    end else begin
      busy_q <= busy_d;
      done_q <= done_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      left_q <= left_d;
      clocks_q <= clocks_d;
      tot_q <= tot_d;
      sub_q <= sub_d;
      rd_left_q <= rd_left_d;
      wr_left_q <= wr_left_d;
      reads_q <= reads_d;
      writes_q <= writes_d;
      tr_q <= tr_d;
      tw_q <= tw_d;
    end
  end

  assign busy_o = busy_q;
  assign done_o = done_q;
  assign read_cycle_o = rd_q;
  assign write_cycle_o = wr_q;
  assign clocks_o = clocks_q;
  assign reads_o = reads_q;
  assign writes_o = writes_q;
endmodule
`default_nettype wire

// File: verification/instr_cycle_timing_chk.sv
// Checker for the instruction timing sequencer ports
`timescale 1ns/1ps
`default_nettype none
module instr_cycle_timing_chk (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire instr_timing_pkg::op_t op_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic read_cycle_o,
  input wire logic write_cycle_o,
  input wire logic [instr_timing_pkg::CLK_W-1:0] clocks_o,
  input wire logic [instr_timing_pkg::BUS_W-1:0] reads_o,
  input wire logic [instr_timing_pkg::BUS_W-1:0] writes_o
);
  import instr_timing_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  a_busy_on_start: assert property (start_i && !busy_o |=> busy_o)
    else $error("busy not raised after start");
  a_done_at_end: assert property ($fell(busy_o) |-> done_o)
    else $error("done missing when busy falls");
  a_done_single: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  a_totals_hold: assert property (!done_o |-> $stable({clocks_o, reads_o, writes_o}))
    else $error("totals changed without done");
  a_bus_in_busy: assert property (read_cycle_o || write_cycle_o |-> busy_o)
    else $error("bus cycle outside instruction");
  a_busy_floor: assert property ($rose(busy_o) |-> busy_o [*8])
    else $error("instruction shorter than 8 clocks");
  a_load_quick: assert property (start_i && !busy_o && op_i == OP_LOAD_QUICK_CONSTANT |->
    ##9 done_o && clocks_o == 8'h08 && reads_o == 5'h02 && writes_o == 5'h00)
    else $error("load quick timing wrong");
  a_call_total: assert property (start_i && !busy_o && op_i == OP_SUBROUTINE_CALL_REL |->
    ##35 done_o && clocks_o == 8'h22 && reads_o == 5'h04 && writes_o == 5'h04)
    else $error("subroutine call timing wrong");
endmodule
bind instr_cycle_timing instr_cycle_timing_chk i_chk (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
  .start_i(start_i), .op_i(op_i), .busy_o(busy_o), .done_o(done_o),
  .read_cycle_o(read_cycle_o), .write_cycle_o(write_cycle_o), .clocks_o(clocks_o),
  .reads_o(reads_o), .writes_o(writes_o));
`default_nettype wire

// File: verification/bus_partner_model.sv
// Bus-side model that counts read and write cycles
`timescale 1ns/1ps
`default_nettype none
module bus_partner_model (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic clear_i,
  input wire logic read_cycle_i,
  input wire logic write_cycle_i,
  output logic [4:0] rd_cnt_o,
  output logic [4:0] wr_cnt_o
);
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_cnt_o <= 5'h00;
      wr_cnt_o <= 5'h00;
    end else if (clear_i) begin
      rd_cnt_o <= 5'h00;
      wr_cnt_o <= 5'h00;
    end else begin
      rd_cnt_o <= rd_cnt_o + 5'(read_cycle_i);
      wr_cnt_o <= wr_cnt_o + 5'(write_cycle_i);
    end
  end
endmodule
`default_nettype wire

// File: verification/instr_cycle_timing_tb.sv
// Testbench for the instruction timing sequencer
`timescale 1ns/1ps
`default_nettype none
module instr_cycle_timing_tb;
  import instr_timing_pkg::*;
  localparam size_t B = SIZE_BYTE, W = SIZE_WORD, L = SIZE_LONG;
  localparam dst_t R = DST_DATA_REG_OPERAND, A = DST_ADDR_REG_OPERAND, M = DST_MEMORY;
  logic ref_clk_i = 1'b0, rstn_i = 1'b0, start_i = 1'b0;
  op_t op_i = OP_TEST_OPERAND;
  size_t size_i = SIZE_BYTE;
  dst_t dst_i = DST_DATA_REG_OPERAND;
  logic word_disp_i = 1'b0, cond_true_i = 1'b0, loop_expired_i = 1'b0, static_bit_i = 1'b0;
  logic [SHIFT_W-1:0] shift_count_i = 6'h00;
  logic [CLK_W-1:0] ea_clocks_i = 8'h04;
  logic [BUS_W-1:0] ea_reads_i = 5'h01, ea_writes_i = 5'h00;
  logic busy_o, done_o, read_cycle_o, write_cycle_o;
  logic [CLK_W-1:0] clocks_o;
  logic [BUS_W-1:0] reads_o, writes_o, rd_cnt, wr_cnt;
  int n_errors = 0, cmp_count = 0;
  always #12.5 ref_clk_i = ~ref_clk_i;
  instr_cycle_timing i_dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .start_i(start_i),
    .op_i(op_i), .size_i(size_i), .dst_i(dst_i), .word_disp_i(word_disp_i),
    .cond_true_i(cond_true_i), .loop_expired_i(loop_expired_i), .static_bit_i(static_bit_i),
    .shift_count_i(shift_count_i), .ea_clocks_i(ea_clocks_i), .ea_reads_i(ea_reads_i),
    .ea_writes_i(ea_writes_i), .busy_o(busy_o), .done_o(done_o), .read_cycle_o(read_cycle_o),
    .write_cycle_o(write_cycle_o), .clocks_o(clocks_o), .reads_o(reads_o), .writes_o(writes_o));
  bus_partner_model i_mem (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .clear_i(start_i && !busy_o), .read_cycle_i(read_cycle_o), .write_cycle_i(write_cycle_o),
    .rd_cnt_o(rd_cnt), .wr_cnt_o(wr_cnt));
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // f = {refused start, cond true, word disp, loop expired, static bit}
  task automatic run(input op_t op, input size_t sz, input dst_t d, input logic [4:0] f,
      input logic [5:0] n, input logic [7:0] ec, input logic [4:0] er, input logic [4:0] ew);
    int k;
    @(posedge ref_clk_i);
    op_i <= op;
    size_i <= sz;
    dst_i <= d;
    {cond_true_i, word_disp_i, loop_expired_i, static_bit_i} <= f[3:0];
    shift_count_i <= n;
    start_i <= 1'b1;
    for (k = 1; k < 300; k++) begin
      @(posedge ref_clk_i);
      start_i <= f[4] && k == 3;
      #1;
      if (done_o === 1'b1) break;
    end
    cmp_count++;
    if (k - 1 != ec || {clocks_o, reads_o, writes_o, rd_cnt, wr_cnt} !== {ec, er, ew, er, ew}) begin
      n_errors++;
      $display("unexpected at %0t: %s took %0d, totals %0d/%0d/%0d", $time, op.name(), k - 1,
        clocks_o, reads_o, writes_o);
    end
    if (k == 300) finish_test();
  endtask
  task automatic t_immediate();
    run(OP_ADD_IMMEDIATE, B, R, 5'h00, 6'h00, 8'h10, 5'h04, 5'h00);
    run(OP_XOR_IMMEDIATE, L, R, 5'h00, 6'h00, 8'h1C, 5'h06, 5'h00);
    run(OP_OR_IMMEDIATE, W, M, 5'h00, 6'h00, 8'h1C, 5'h05, 5'h02);
    run(OP_AND_IMMEDIATE, L, M, 5'h00, 6'h00, 8'h2C, 5'h07, 5'h04);
    run(OP_SUBTRACT_IMMEDIATE, B, M, 5'h00, 6'h00, 8'h10, 5'h03, 5'h01);
    run(OP_COMPARE_IMMEDIATE, L, R, 5'h00, 6'h00, 8'h1A, 5'h06, 5'h00);
    run(OP_COMPARE_IMMEDIATE, L, M, 5'h00, 6'h00, 8'h18, 5'h06, 5'h00);
    run(OP_ADD_QUICK, L, R, 5'h00, 6'h00, 8'h0C, 5'h02, 5'h00);
    run(OP_SUBTRACT_QUICK, W, A, 5'h00, 6'h00, 8'h0C, 5'h02, 5'h00);
    run(OP_LOAD_QUICK_CONSTANT, L, R, 5'h00, 6'h00, 8'h08, 5'h02, 5'h00);
    run(OP_SUBTRACT_IMMEDIATE, L, R, 5'h00, 6'h00, 8'h1C, 5'h06, 5'h00);
    run(OP_COMPARE_IMMEDIATE, B, M, 5'h00, 6'h00, 8'h10, 5'h04, 5'h00);
    run(OP_ADD_QUICK, B, R, 5'h00, 6'h00, 8'h08, 5'h02, 5'h00);
    run(OP_ADD_QUICK, W, M, 5'h00, 6'h00, 8'h14, 5'h03, 5'h02);
    run(OP_SUBTRACT_QUICK, L, M, 5'h00, 6'h00, 8'h2C, 5'h07, 5'h04);
    $display("test immediate and quick finished");
  endtask
  task automatic t_single();
    run(OP_CLEAR_OPERAND, L, R, 5'h00, 6'h00, 8'h0A, 5'h02, 5'h00);
    run(OP_NEGATE_WITH_EXTEND, L, M, 5'h00, 6'h00, 8'h1C, 5'h03, 5'h04);
    run(OP_DECIMAL_NEGATE, B, R, 5'h00, 6'h00, 8'h0A, 5'h02, 5'h00);
    run(OP_SET_ON_CONDITION, B, R, 5'h08, 6'h00, 8'h0A, 5'h02, 5'h00);
    run(OP_TEST_AND_SET_OPERAND, B, M, 5'h00, 6'h00, 8'h12, 5'h03, 5'h01);
    run(OP_TEST_OPERAND, W, M, 5'h00, 6'h00, 8'h0C, 5'h03, 5'h00);
    run(OP_INVERT_OPERAND, B, R, 5'h00, 6'h00, 8'h08, 5'h02, 5'h00);
    run(OP_DECIMAL_NEGATE, B, M, 5'h00, 6'h00, 8'h10, 5'h03, 5'h01);
    run(OP_SET_ON_CONDITION, B, R, 5'h00, 6'h00, 8'h08, 5'h02, 5'h00);
    run(OP_SET_ON_CONDITION, B, M, 5'h08, 6'h00, 8'h10, 5'h03, 5'h01);
    run(OP_TEST_AND_SET_OPERAND, B, R, 5'h00, 6'h00, 8'h08, 5'h02, 5'h00);
    run(OP_TEST_OPERAND, L, R, 5'h00, 6'h00, 8'h08, 5'h02, 5'h00);
    @(posedge ref_clk_i);
    ea_clocks_i <= 8'h08;
    ea_writes_i <= 5'h01;
    run(OP_TWOS_NEGATE, W, M, 5'h00, 6'h00, 8'h18, 5'h03, 5'h03);
    @(posedge ref_clk_i);
    ea_clocks_i <= 8'h04;
    ea_writes_i <= 5'h00;
    $display("test single operand finished");
  endtask
  task automatic t_shift_bits();
    run(OP_ARITHMETIC_SHIFT, B, R, 5'h00, 6'h00, 8'h0A, 5'h02, 5'h00);
    run(OP_ROTATE_THROUGH_EXTEND, L, R, 5'h00, 6'h3C, 8'h84, 5'h02, 5'h00);
    run(OP_LOGICAL_SHIFT, W, M, 5'h00, 6'h05, 8'h14, 5'h03, 5'h02);
    run(OP_BIT_CLEAR_OP, L, R, 5'h00, 6'h00, 8'h0E, 5'h02, 5'h00);
    run(OP_BIT_TEST_OP, B, M, 5'h00, 6'h00, 8'h0C, 5'h03, 5'h00);
    run(OP_BIT_TOGGLE, L, R, 5'h01, 6'h00, 8'h14, 5'h04, 5'h00);
    run(OP_BIT_SET_OP, B, M, 5'h01, 6'h00, 8'h18, 5'h05, 5'h01);
    run(OP_PLAIN_ROTATE, W, R, 5'h00, 6'h03, 8'h10, 5'h02, 5'h00);
    run(OP_LOGICAL_SHIFT, L, R, 5'h00, 6'h01, 8'h0E, 5'h02, 5'h00);
    run(OP_BIT_TOGGLE, B, R, 5'h00, 6'h00, 8'h0C, 5'h02, 5'h00);
    run(OP_BIT_SET_OP, L, M, 5'h00, 6'h00, 8'h10, 5'h03, 5'h01);
    run(OP_BIT_CLEAR_OP, L, R, 5'h01, 6'h00, 8'h16, 5'h04, 5'h00);
    run(OP_BIT_TEST_OP, L, R, 5'h01, 6'h00, 8'h12, 5'h04, 5'h00);
    run(OP_BIT_TEST_OP, B, M, 5'h01, 6'h00, 8'h14, 5'h05, 5'h00);
    $display("test shift and bit finished");
  endtask
  task automatic t_branch();
    run(OP_CONDITIONAL_BRANCH, B, R, 5'h08, 6'h00, 8'h12, 5'h04, 5'h00);
    run(OP_CONDITIONAL_BRANCH, W, R, 5'h04, 6'h00, 8'h14, 5'h04, 5'h00);
    run(OP_SUBROUTINE_CALL_REL, W, R, 5'h00, 6'h00, 8'h22, 5'h04, 5'h04);
    run(OP_LOOP_DECREMENT_BRANCH, W, R, 5'h02, 6'h00, 8'h1A, 5'h06, 5'h00);
    run(OP_BOUNDS_CHECK_EXCEPTION, W, R, 5'h08, 6'h00, 8'h48, 5'h09, 5'h06);
    run(OP_SOFTWARE_EXCEPTION, W, R, 5'h00, 6'h00, 8'h3E, 5'h08, 5'h06);
    run(OP_OVERFLOW_EXCEPTION, W, R, 5'h10, 6'h00, 8'h08, 5'h02, 5'h00);
    run(OP_CONDITIONAL_BRANCH, B, R, 5'h00, 6'h00, 8'h0C, 5'h02, 5'h00);
    run(OP_UNCONDITIONAL_JUMP_REL, W, R, 5'h00, 6'h00, 8'h12, 5'h04, 5'h00);
    run(OP_LOOP_DECREMENT_BRANCH, W, R, 5'h08, 6'h00, 8'h14, 5'h04, 5'h00);
    run(OP_LOOP_DECREMENT_BRANCH, W, R, 5'h00, 6'h00, 8'h12, 5'h04, 5'h00);
    run(OP_BOUNDS_CHECK_EXCEPTION, W, R, 5'h00, 6'h00, 8'h0E, 5'h02, 5'h00);
    run(OP_OVERFLOW_EXCEPTION, W, R, 5'h08, 6'h00, 8'h42, 5'h0A, 5'h06);
    $display("test branch and exception finished");
  endtask
  initial begin
    repeat (5) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    t_immediate();
    t_single();
    t_shift_bits();
    t_branch();
    finish_test();
  end
endmodule
`default_nettype wire
